// ### core/i2c_bank_pkg.sv
// Shared constants and types for the register-bank serial link and its controller.
// -----------------------------------------------------------------------------
// -----------------------------------------------------------------------------
`default_nettype none

package i2c_bank_pkg;

  // ---------------------------------------------------------------------------
  // Register bank of the device end
  // ---------------------------------------------------------------------------
  localparam logic [4:0] DEV_ADDR_BASE             = 5'h08;
  localparam logic [6:0] RW_LAST                   = 7'h50;
  localparam logic [6:0] SOFT_CLIP_CONTROL         = 7'h0A;
  localparam logic [6:0] FAULT_HANDLING_CONTROL    = 7'h2D;
  localparam logic [6:0] CHANNEL0_MODULATION_INDEX = 7'h62;
  localparam logic [6:0] CHANNEL1_MODULATION_INDEX = 7'h66;
  localparam logic [6:0] ACCUMULATED_FAULT_FLAGS   = 7'h6D;
  localparam logic [6:0] LIVE_FAULT_FLAGS          = 7'h7C;
  localparam int         SOFT_CLIP_BIT             = 7;
  localparam int         FAULT_HISTORY_CLEAR_BIT   = 2;
  localparam logic [7:0] BANK_RESET                = 8'h00;

  typedef struct packed {
    logic dc_fault;
    logic pin_short_fault;
    logic overtemp_fault;
    logic overtemp_warning;
    logic undervoltage;
    logic clock_loop_fault;
    logic overcurrent_fault;
    logic other_fault;
  } fault_vec_t;

  // ---------------------------------------------------------------------------
  // Link timing of the controller end
  // ---------------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 50;
  localparam int SCL_RATE_KBPS = 100;
  localparam int SCL_PERIOD_NS = 1000000 / SCL_RATE_KBPS;
  localparam int QTR_CYC       = (SCL_PERIOD_NS + 4 * CLK_PERIOD_NS - 1) / (4 * CLK_PERIOD_NS);

  // ---------------------------------------------------------------------------
  // Controller registers on its AXI4-Lite port
  // ---------------------------------------------------------------------------
  localparam logic [11:0] CMD_OFFSET    = 12'h000;
  localparam logic [11:0] STATUS_OFFSET = 12'h004;
  localparam int          CMD_ACK_BIT   = 2;
  localparam int          DATA_LSB      = 8;
  localparam int          STAT_ACK_BIT  = 1;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;

  typedef enum logic [1:0] {
    OP_START = 2'h0,
    OP_STOP  = 2'h1,
    OP_WRITE = 2'h2,
    OP_READ  = 2'h3
  } op_t;

endpackage : i2c_bank_pkg

`default_nettype wire

// ### core/i2c_link_if.sv
// Two-wire link between the controller end and the register-bank end.
`default_nettype none

interface i2c_link_if;
  logic m_scl_o;     // Controller clock drive value
  logic m_scl_oe_b;  // Controller clock enable, low drives
  logic m_sda_o;     // Controller data drive value
  logic m_sda_oe_b;  // Controller data enable, low drives
  logic s_sda_o;     // Device data drive value
  logic s_sda_oe_b;  // Device data enable, low drives
  logic scl;         // Resolved clock wire
  logic sda;         // Resolved data wire

  // Pull-ups make a released wire high; any driver pulling low wins.
  assign scl = m_scl_oe_b | m_scl_o;
  assign sda = (m_sda_oe_b | m_sda_o) & (s_sda_oe_b | s_sda_o);

  modport device (input scl, input sda, output s_sda_o, output s_sda_oe_b);
  modport host (input scl, input sda, output m_scl_o, output m_scl_oe_b, output m_sda_o, output m_sda_oe_b);
endinterface : i2c_link_if

`default_nettype wire

// ### core/i2c_bank_slave.sv
// Device end: serial slave giving the link access to the register bank.
`default_nettype none

module i2c_bank_slave (
  input  wire logic                     clk,              // Core clock, 20 MHz
  input  wire logic                     rst_b,            // Synchronous reset, active low
  i2c_link_if.device                    link,             // Two-wire link
  input  wire logic                     addr_select_low,  // Address select pin, bit 0
  input  wire logic                     addr_select_high, // Address select pin, bit 1
  input  wire logic                     near_clip,        // Output close to clipping
  input  wire i2c_bank_pkg::fault_vec_t fault_src,        // Live fault sources
  input  wire logic [7:0]               mod_index_ch0,    // Modulation index, channel 0
  input  wire logic [7:0]               mod_index_ch1,    // Modulation index, channel 1
  output var  logic                     soft_clip_en,     // Soft-clip scheme enable
  output var  logic                     clip_pin_o,       // Clip pin drive value
  output var  logic                     clip_pin_oe_b,    // Clip pin enable, low pulls low
  output var  logic                     fault_pin_o,      // Fault pin drive value
  output var  logic                     fault_pin_oe_b    // Fault pin enable, low pulls low
);
  import i2c_bank_pkg::*;

  typedef enum logic [3:0] {
    ST_IDLE      = 4'h0,
    ST_ADDR      = 4'h1,
    ST_ADDR_ACK  = 4'h3,
    ST_REG       = 4'h2,
    ST_REG_ACK   = 4'h6,
    ST_WDATA     = 4'h7,
    ST_WDATA_ACK = 4'h5,
    ST_RDATA     = 4'h4,
    ST_RDATA_ACK = 4'hC
  } slave_state_t;

  slave_state_t state_q;
  logic [2:0]   scl_sq;
  logic [2:0]   sda_sq;
  logic [1:0]   sel_lo_sq;
  logic [1:0]   sel_hi_sq;
  logic [2:0]   bit_cnt_q;
  logic [6:0]   shift_q;
  logic         rw_q;
  logic [6:0]   ptr_q;
  logic [7:0]   tx_q;
  logic         sda_rel_q;
  logic [7:0]   mem_q [0:RW_LAST];
  fault_vec_t   acc_q;
  logic         clr_prev_q;
  logic [7:0]   rd_data;
  logic         scl_rise;
  logic         scl_fall;
  logic         start_det;
  logic         stop_det;
  logic         byte_done;
  logic [7:0]   rx_byte;
  logic [6:0]   own_addr;
  logic         load_tx;
  logic         clear_hist;

  // ---------------------------------------------------------------------------
  // Synchronisers and edge detection
  // ---------------------------------------------------------------------------
  // The link wires and select pins come from outside this clock domain; only
  // the second stage and its delayed copy feed any logic.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      scl_sq    <= 3'h7;
      sda_sq    <= 3'h7;
      sel_lo_sq <= 2'h0;
      sel_hi_sq <= 2'h0;
    end else begin
      scl_sq    <= {scl_sq[1:0], link.scl};
      sda_sq    <= {sda_sq[1:0], link.sda};
      sel_lo_sq <= {sel_lo_sq[0], addr_select_low};
      sel_hi_sq <= {sel_hi_sq[0], addr_select_high};
    end
  end

  assign scl_rise  = scl_sq[1] & ~scl_sq[2];
  assign scl_fall  = ~scl_sq[1] & scl_sq[2];
  assign start_det = scl_sq[1] & scl_sq[2] & sda_sq[2] & ~sda_sq[1];
  assign stop_det  = scl_sq[1] & scl_sq[2] & ~sda_sq[2] & sda_sq[1];
  assign rx_byte   = {shift_q, sda_sq[1]};
  assign byte_done = scl_rise & (bit_cnt_q == 3'h7);
  assign own_addr  = {DEV_ADDR_BASE, sel_hi_sq[1], sel_lo_sq[1]};
  assign load_tx   = scl_rise & (((state_q == ST_ADDR_ACK) & rw_q) |
                                 ((state_q == ST_RDATA_ACK) & ~sda_sq[1]));

  // ---------------------------------------------------------------------------
  // Transfer sequencing
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state_q   <= ST_IDLE;
      bit_cnt_q <= 3'h0;
      shift_q   <= 7'h00;
      rw_q      <= 1'b0;
    end else if (start_det) begin
      state_q   <= ST_ADDR;
      bit_cnt_q <= 3'h0;
    end else if (stop_det) begin
      state_q   <= ST_IDLE;
    end else if (scl_rise) begin
      case (state_q)
        ST_ADDR, ST_REG, ST_WDATA: begin
          shift_q   <= rx_byte[6:0];
          bit_cnt_q <= bit_cnt_q + 3'h1;
          if (bit_cnt_q == 3'h7) begin
            if (state_q == ST_ADDR) begin
              rw_q    <= sda_sq[1];
              state_q <= (shift_q == own_addr) ? ST_ADDR_ACK : ST_IDLE;
            end else begin
              state_q <= (state_q == ST_REG) ? ST_REG_ACK : ST_WDATA_ACK;
            end
          end
        end
        ST_ADDR_ACK: begin
          state_q <= rw_q ? ST_RDATA : ST_REG;
        end
        ST_REG_ACK, ST_WDATA_ACK: begin
          state_q <= ST_WDATA;
        end
        ST_RDATA: begin
          bit_cnt_q <= bit_cnt_q + 3'h1;
          if (bit_cnt_q == 3'h7) begin
            state_q <= ST_RDATA_ACK;
          end
        end
        ST_RDATA_ACK: begin
          // A withheld acknowledge ends the read; the wire stays free until stop.
          state_q <= sda_sq[1] ? ST_IDLE : ST_RDATA;
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // Bank pointer and transmit byte
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ptr_q <= 7'h00;
    end else if (byte_done && state_q == ST_REG) begin
      ptr_q <= rx_byte[6:0];
    end else if (byte_done && state_q == ST_WDATA) begin
      ptr_q <= ptr_q + 7'h1;
    end else if (load_tx) begin
      ptr_q <= ptr_q + 7'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      tx_q <= 8'hFF;
    end else if (load_tx) begin
      tx_q <= rd_data;
    end else if (scl_rise && state_q == ST_RDATA) begin
      tx_q <= {tx_q[6:0], 1'b1};
    end
  end

  // ---------------------------------------------------------------------------
  // Data line drive
  // ---------------------------------------------------------------------------
  // The line only changes after a detected falling clock edge, so the slave
  // never makes a data edge while the clock is high.
  always_ff @(posedge clk) begin
    if (!rst_b || start_det || stop_det) begin
      sda_rel_q <= 1'b1;
    end else if (scl_fall) begin
      case (state_q)
        ST_ADDR_ACK, ST_REG_ACK, ST_WDATA_ACK: begin
          sda_rel_q <= 1'b0;
        end
        ST_RDATA: begin
          sda_rel_q <= tx_q[7];
        end
        default: begin
          sda_rel_q <= 1'b1;
        end
      endcase
    end
  end

  assign link.s_sda_oe_b = sda_rel_q;
  assign link.s_sda_o    = 1'b0;

  // ---------------------------------------------------------------------------
  // Register bank
  // ---------------------------------------------------------------------------
  // Only locations up to RW_LAST have storage; a write elsewhere is still
  // acknowledged so a long burst never stalls on a status location.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      for (int i = 0; i <= int'(RW_LAST); i++) begin
        mem_q[i] <= BANK_RESET;
      end
    end else if (byte_done && state_q == ST_WDATA && ptr_q <= RW_LAST) begin
      mem_q[ptr_q] <= rx_byte;
    end
  end

  always_comb begin
    rd_data = 8'h00;
    if (ptr_q <= RW_LAST) begin
      rd_data = mem_q[ptr_q];
    end else begin
      case (ptr_q)
        CHANNEL0_MODULATION_INDEX: rd_data = mod_index_ch0;
        CHANNEL1_MODULATION_INDEX: rd_data = mod_index_ch1;
        ACCUMULATED_FAULT_FLAGS:   rd_data = acc_q;
        LIVE_FAULT_FLAGS:          rd_data = fault_src;
        default:                   rd_data = 8'h00;
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // Fault history
  // ---------------------------------------------------------------------------
  // Either edge of the clear bit empties the history; a fault live in that
  // same cycle is kept, so no event is lost to a clear.
  assign clear_hist = mem_q[FAULT_HANDLING_CONTROL][FAULT_HISTORY_CLEAR_BIT] ^ clr_prev_q;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      acc_q      <= '0;
      clr_prev_q <= 1'b0;
    end else begin
      clr_prev_q <= mem_q[FAULT_HANDLING_CONTROL][FAULT_HISTORY_CLEAR_BIT];
      acc_q      <= clear_hist ? fault_src : (acc_q | fault_src);
    end
  end

  // ---------------------------------------------------------------------------
  // Pins and controls
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      soft_clip_en   <= 1'b0;
      clip_pin_o     <= 1'b0;
      clip_pin_oe_b  <= 1'b1;
      fault_pin_o    <= 1'b0;
      fault_pin_oe_b <= 1'b1;
    end else begin
      soft_clip_en   <= mem_q[SOFT_CLIP_CONTROL][SOFT_CLIP_BIT];
      clip_pin_o     <= 1'b0;
      clip_pin_oe_b  <= ~near_clip;
      fault_pin_o    <= 1'b0;
      fault_pin_oe_b <= ~(|fault_src);
    end
  end

endmodule : i2c_bank_slave

`default_nettype wire

// ### core/i2c_bank_master.sv
// Controller end: AXI4-Lite commanded two-wire master for the register bank.
`default_nettype none

module i2c_bank_master #(
  parameter int QTR = i2c_bank_pkg::QTR_CYC  // Clock cycles per quarter bit
) (
  input  wire logic        clk,      // Core clock, 20 MHz
  input  wire logic        rst_b,    // Synchronous reset, active low
  i2c_link_if.host         link,     // Two-wire link
  input  wire logic [11:0] awaddr,   // Write address
  input  wire logic        awvalid,  // Write address valid
  output var  logic        awready,  // Write address ready
  input  wire logic [31:0] wdata,    // Write data
  input  wire logic [3:0]  wstrb,    // Write strobes, not used
  input  wire logic        wvalid,   // Write data valid
  output var  logic        wready,   // Write data ready
  output var  logic [1:0]  bresp,    // Write response
  output var  logic        bvalid,   // Write response valid
  input  wire logic        bready,   // Write response ready
  input  wire logic [11:0] araddr,   // Read address
  input  wire logic        arvalid,  // Read address valid
  output var  logic        arready,  // Read address ready
  output var  logic [31:0] rdata,    // Read data
  output var  logic [1:0]  rresp,    // Read response
  output var  logic        rvalid,   // Read data valid
  input  wire logic        rready    // Read data ready
);
  import i2c_bank_pkg::*;

  localparam int DIV_W = $clog2(QTR + 1);

  typedef enum logic [1:0] {
    M_IDLE  = 2'h0,
    M_START = 2'h1,
    M_BITS  = 2'h3,
    M_STOP  = 2'h2
  } mst_state_t;

  mst_state_t       mst_q;
  logic [11:0]      awaddr_q;
  logic [31:0]      wdata_q;
  logic             go_q;
  op_t              op_q;
  logic [2:0]       sda_sq;
  logic [DIV_W-1:0] div_q;
  logic [1:0]       phase_q;
  logic [3:0]       bitn_q;
  logic [8:0]       tx_q;
  logic [8:0]       rx_q;
  logic             scl_rel_q;
  logic             sda_rel_q;
  logic             aw_got_q;
  logic             w_got_q;
  logic             busy;
  logic             tick;

  assign busy = (mst_q != M_IDLE) | go_q;
  assign tick = div_q == DIV_W'(QTR - 1);

  // ---------------------------------------------------------------------------
  // AXI4-Lite write path
  // ---------------------------------------------------------------------------
  // A command written while busy is refused with SLVERR rather than queued.
  // Separate take flags keep the low readies after reset from looking like a
  // finished address and data pair, which would launch a command nobody wrote.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      awready  <= 1'b0;
      wready   <= 1'b0;
      bvalid   <= 1'b0;
      bresp    <= RESP_OKAY;
      awaddr_q <= 12'h000;
      wdata_q  <= 32'h0000_0000;
      go_q     <= 1'b0;
      op_q     <= OP_START;
      aw_got_q <= 1'b0;
      w_got_q  <= 1'b0;
    end else begin
      go_q <= 1'b0;
      if (awvalid && awready) begin
        awaddr_q <= awaddr;
        awready  <= 1'b0;
        aw_got_q <= 1'b1;
      end
      if (wvalid && wready) begin
        wdata_q <= wdata;
        wready  <= 1'b0;
        w_got_q <= 1'b1;
      end
      if (aw_got_q && w_got_q) begin
        aw_got_q <= 1'b0;
        w_got_q  <= 1'b0;
        if (awaddr_q == CMD_OFFSET && !busy) begin
          go_q  <= 1'b1;
          op_q  <= op_t'(wdata_q[1:0]);
          bresp <= RESP_OKAY;
        end else begin
          bresp <= RESP_SLVERR;
        end
        bvalid <= 1'b1;
      end else if (bvalid && bready) begin
        bvalid  <= 1'b0;
        awready <= 1'b1;
        wready  <= 1'b1;
      end else if (!bvalid && !aw_got_q && !w_got_q && !awready && !wready) begin
        awready <= 1'b1;
        wready  <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // AXI4-Lite read path
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      arready <= 1'b0;
      rvalid  <= 1'b0;
      rdata   <= 32'h0000_0000;
      rresp   <= RESP_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid  <= 1'b1;
      rresp   <= (araddr == STATUS_OFFSET || araddr == CMD_OFFSET) ? RESP_OKAY : RESP_SLVERR;
      rdata   <= 32'h0000_0000;
      if (araddr == STATUS_OFFSET) begin
        rdata <= {16'h0000, rx_q[8:1], 6'h00, rx_q[0], busy};
      end else if (araddr == CMD_OFFSET) begin
        rdata <= wdata_q;
      end
    end else if (rvalid && rready) begin
      rvalid  <= 1'b0;
      arready <= 1'b1;
    end else if (!rvalid) begin
      arready <= 1'b1;
    end
  end

  // ---------------------------------------------------------------------------
  // Link sequencer
  // ---------------------------------------------------------------------------
  // Each operation runs in quarter-bit phases; outside start and stop, data
  // changes only with the clock low and is sampled mid-high. A byte operation assumes the clock is
  // already low, so software must issue a start first.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      sda_sq <= 3'h7;
    end else begin
      sda_sq <= {sda_sq[1:0], link.sda};
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      mst_q     <= M_IDLE;
      div_q     <= '0;
      phase_q   <= 2'h0;
      bitn_q    <= 4'h0;
      tx_q      <= 9'h1FF;
      rx_q      <= 9'h000;
      scl_rel_q <= 1'b1;
      sda_rel_q <= 1'b1;
    end else if (mst_q == M_IDLE) begin
      div_q   <= '0;
      phase_q <= 2'h0;
      bitn_q  <= 4'h0;
      if (go_q) begin
        case (op_q)
          OP_START: mst_q <= M_START;
          OP_STOP:  mst_q <= M_STOP;
          default:  mst_q <= M_BITS;
        endcase
        tx_q <= (op_q == OP_READ) ? {8'hFF, ~wdata_q[CMD_ACK_BIT]}
                                  : {wdata_q[DATA_LSB +: 8], 1'b1};
      end
    end else begin
      div_q <= tick ? '0 : div_q + DIV_W'(1);
      if (tick) begin
        phase_q <= phase_q + 2'h1;
        case (mst_q)
          M_START: begin
            case (phase_q)
              2'h0: sda_rel_q <= 1'b1;
              2'h1: scl_rel_q <= 1'b1;
              2'h2: sda_rel_q <= 1'b0;
              default: begin
                scl_rel_q <= 1'b0;
                mst_q     <= M_IDLE;
              end
            endcase
          end
          M_STOP: begin
            case (phase_q)
              2'h0: sda_rel_q <= 1'b0;
              2'h1: scl_rel_q <= 1'b1;
              2'h2: sda_rel_q <= 1'b1;
              default: mst_q <= M_IDLE;
            endcase
          end
          default: begin
            case (phase_q)
              2'h0: sda_rel_q <= tx_q[8];
              2'h1: scl_rel_q <= 1'b1;
              2'h2: rx_q <= {rx_q[7:0], sda_sq[1]};
              default: begin
                scl_rel_q <= 1'b0;
                tx_q      <= {tx_q[7:0], 1'b1};
                bitn_q    <= bitn_q + 4'h1;
                if (bitn_q == 4'h8) begin
                  mst_q <= M_IDLE;
                end
              end
            endcase
          end
        endcase
      end
    end
  end

  assign link.m_scl_oe_b = scl_rel_q;
  assign link.m_scl_o    = 1'b0;
  assign link.m_sda_oe_b = sda_rel_q;
  assign link.m_sda_o    = 1'b0;

endmodule : i2c_bank_master

`default_nettype wire

// ### testbench/i2c_link_checker.sv
// Concurrent checks on the two-wire link between the two ends.
`default_nettype none
module i2c_link_checker (
  input wire logic clk,        // Core clock
  input wire logic rst_b,      // Reset, active low
  input wire logic scl,        // Clock wire
  input wire logic sda,        // Data wire
  input wire logic s_sda_oe_b, // Device data enable
  input wire logic m_sda_oe_b, // Controller data enable
  input wire logic m_scl_oe_b  // Controller clock enable
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // ------
  // Wire checks
  // ------
  rst_rel_a: assert property ($rose(rst_b) |-> s_sda_oe_b && m_sda_oe_b && m_scl_oe_b)
    else $error("Link driven out of reset.");
  hold_high_a: assert property (scl && $past(scl) |-> $stable(s_sda_oe_b))
    else $error("Device data moved with clock high.");
  ack_low_a: assert property ($fell(s_sda_oe_b) |-> !scl)
    else $error("Device drive began with clock high.");
  rel_low_a: assert property ($rose(s_sda_oe_b) |-> !scl)
    else $error("Device released with clock high.");
  scl_high_a: assert property ($rose(scl) |-> scl [*4])
    else $error("Clock high too short.");
  scl_low_a: assert property ($fell(scl) |-> !scl [*4])
    else $error("Clock low too short.");
  start_hold_a: assert property ($fell(sda) && scl |-> scl [*4])
    else $error("Clock fell too soon after start.");
  stop_idle_a: assert property ($rose(sda) && scl && $past(scl) |-> scl [*8])
    else $error("Clock moved after stop.");
  start_c: cover property ($fell(sda) && scl);
  ack_c: cover property (!s_sda_oe_b && $rose(scl));
  stop_c: cover property ($rose(sda) && scl);
endmodule : i2c_link_checker
`default_nettype wire

// ### testbench/tb_i2c_register_bank_slave.sv
// Self-checking bench joining the controller end and the register-bank end.
`default_nettype none
module tb_i2c_register_bank_slave;
  timeunit 1ns;
  timeprecision 1ns;
  import i2c_bank_pkg::*;
  // ------
  // Signals and the two ends
  // ------
  logic        clk = '0, rst_b = '0, near_clip = '0, addr_select_low = '0, addr_select_high = '0;
  logic        awvalid = '0, wvalid = '0, bready = '0, arvalid = '0, rready = '0;
  logic        awready, wready, bvalid, arready, rvalid, soft_clip_en, clip_pin_oe_b, fault_pin_oe_b;
  logic [11:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata;
  logic [3:0]  wstrb = 4'hF;
  logic [1:0]  bresp, rresp;
  logic [7:0]  mod_index_ch0 = 8'h5A, mod_index_ch1 = 8'hC3;
  logic [6:0]  dev = 7'h20;
  fault_vec_t  fault_src = '0;
  int          err_count = 0, n_checks = 0;
  i2c_link_if lnk ();
  i2c_bank_slave i_i2c_bank_slave (.clk, .rst_b, .link(lnk), .addr_select_low, .addr_select_high, .near_clip,
    .fault_src, .mod_index_ch0, .mod_index_ch1, .soft_clip_en, .clip_pin_o(), .clip_pin_oe_b, .fault_pin_o(),
    .fault_pin_oe_b);
  i2c_bank_master #(.QTR(5)) i_i2c_bank_master (.clk, .rst_b, .link(lnk), .awaddr, .awvalid, .awready, .wdata,
    .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
    .rready);
  i2c_link_checker i_i2c_link_checker (.clk, .rst_b, .scl(lnk.scl), .sda(lnk.sda), .s_sda_oe_b(lnk.s_sda_oe_b),
    .m_sda_oe_b(lnk.m_sda_oe_b), .m_scl_oe_b(lnk.m_scl_oe_b));
  always #25 clk = ~clk;
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic results();
    $display("checks=%0d errors=%0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : results
  // Address and data are offered together and each is dropped once taken.
  task automatic axw(input logic [11:0] a, input logic [31:0] d, input logic [1:0] exp);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
    end while (awvalid | wvalid);
    do @(posedge clk); while (!bvalid);
    bready <= 1'h0;
    chk(8'(bresp), 8'(exp));
  endtask : axw
  task automatic axr(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do @(posedge clk); while (!arready);
    arvalid <= 1'h0;
    do @(posedge clk); while (!rvalid);
    rready <= 1'h0;
    d = rdata;
    r = rresp;
  endtask : axr
  task automatic cmd(input op_t op, input logic [7:0] b, input logic ack, output logic [31:0] st);
    logic [1:0] r;
    axw(CMD_OFFSET, {16'h0, b, 5'h0, ack, op}, RESP_OKAY);
    do axr(STATUS_OFFSET, st, r); while (st[0]);
  endtask : cmd
  task automatic ss(input op_t op);
    logic [31:0] st;
    cmd(op, 8'h00, 1'h0, st);
  endtask : ss
  task automatic wb(input logic [7:0] b, input logic nak);
    logic [31:0] st;
    cmd(OP_WRITE, b, 1'h0, st);
    chk(8'(st[STAT_ACK_BIT]), 8'(nak));
  endtask : wb
  task automatic rb(input logic ack, input logic [7:0] exp);
    logic [31:0] st;
    cmd(OP_READ, 8'h00, ack, st);
    chk(st[15:8], exp);
  endtask : rb
  task automatic ptr(input logic [6:0] loc);
    ss(OP_START);
    wb({dev, 1'h0}, 1'h0);
    wb({1'h0, loc}, 1'h0);
  endtask : ptr
  task automatic wr1(input logic [6:0] loc, input logic [7:0] d);
    ptr(loc);
    wb(d, 1'h0);
    ss(OP_STOP);
  endtask : wr1
  task automatic rd1(input logic [6:0] loc, input logic [7:0] exp);
    ptr(loc);
    ss(OP_START);
    wb({dev, 1'h1}, 1'h0);
    rb(1'h0, exp);
    ss(OP_STOP);
  endtask : rd1
  task automatic t_bank();
    logic [31:0] d;
    logic [1:0]  r;
    wr1(SOFT_CLIP_CONTROL, 8'h80);
    chk(8'(soft_clip_en), 8'h01);
    chk(8'({lnk.scl, lnk.sda}), 8'h03);
    ptr(RW_LAST - 7'h01);
    wb(8'h11, 1'h0);
    wb(8'h22, 1'h0);
    wb(8'h33, 1'h0);
    ss(OP_STOP);
    ptr(RW_LAST - 7'h01);
    ss(OP_START);
    wb({dev, 1'h1}, 1'h0);
    rb(1'h1, 8'h11);
    rb(1'h1, 8'h22);
    rb(1'h0, 8'h00);
    ss(OP_STOP);
    wr1(CHANNEL0_MODULATION_INDEX, 8'hFF);
    rd1(CHANNEL0_MODULATION_INDEX, 8'h5A);
    rd1(CHANNEL1_MODULATION_INDEX, 8'hC3);
    axw(12'h008, '0, RESP_SLVERR);
    axr(12'h00C, d, r);
    chk(8'(r), 8'(RESP_SLVERR));
    $display("t_bank done");
  endtask : t_bank
  task automatic t_fault();
    fault_src.dc_fault <= 1'h1;
    fault_src.overcurrent_fault <= 1'h1;
    near_clip <= 1'h1;
    repeat (3) @(posedge clk);
    chk(8'({fault_pin_oe_b, clip_pin_oe_b}), 8'h00);
    rd1(LIVE_FAULT_FLAGS, 8'h82);
    fault_src <= '0;
    near_clip <= 1'h0;
    rd1(LIVE_FAULT_FLAGS, 8'h00);
    rd1(ACCUMULATED_FAULT_FLAGS, 8'h82);
    wr1(FAULT_HANDLING_CONTROL, 8'h04);
    wr1(FAULT_HANDLING_CONTROL, 8'h00);
    rd1(ACCUMULATED_FAULT_FLAGS, 8'h00);
    chk(8'({fault_pin_oe_b, clip_pin_oe_b}), 8'h03);
    $display("t_fault done");
  endtask : t_fault
  task automatic t_addr();
    ss(OP_START);
    wb(8'h42, 1'h1);
    ss(OP_STOP);
    addr_select_high <= 1'h1;
    dev = 7'h22;
    repeat (4) @(posedge clk);
    ss(OP_START);
    wb(8'h42, 1'h1);
    ss(OP_STOP);
    rd1(SOFT_CLIP_CONTROL, 8'h80);
    $display("t_addr done");
  endtask : t_addr
  initial begin
    repeat (6) @(posedge clk);
    rst_b <= 1'h1;
    repeat (4) @(posedge clk);
    t_bank();
    t_fault();
    t_addr();
    results();
  end
  // The run needs about half a millisecond; this bound leaves ample slack.
  initial begin
    #3000000;
    err_count++;
    results();
  end
endmodule : tb_i2c_register_bank_slave
`default_nettype wire
